// >>> src/isp_defines.svh
`ifndef ISP_DEFINES_SVH
`define ISP_DEFINES_SVH

// clock and oversampling
`define ISP_CLK_HZ       40000000
`define ISP_OVERSAMPLE   16

// selectable bit rates in baud
`define ISP_BAUD_300     300
`define ISP_BAUD_600     600
`define ISP_BAUD_1200    1200
`define ISP_BAUD_2400    2400
`define ISP_BAUD_4800    4800
`define ISP_BAUD_9600    9600

// register offsets
`define ISP_REG_CTRL     4'h0
`define ISP_REG_STATUS   4'h4
`define ISP_REG_TXDATA   4'h8
`define ISP_REG_RXDATA   4'hc

// control fields and reset values
`define ISP_CTRL_BAUD_LSB  0
`define ISP_CTRL_FMT_LSB   3
`define ISP_BAUD_SEL_RST   3'h5
`define ISP_FMT_RST        2'h0

// status bit positions
`define ISP_ST_TX_FULL   0
`define ISP_ST_TX_BUSY   1
`define ISP_ST_RX_VALID  2
`define ISP_ST_OVERRUN   3
`define ISP_ST_FRAME_ERR 4
`define ISP_ST_PAR_ERR   5
`define ISP_ST_DSR       6
`define ISP_ST_DTR       7

// frame timing in bit and tick counts
`define ISP_TX_LAST_BIT  4'ha
`define ISP_RX_LAST_BIT  4'h9
`define ISP_TICK_LAST    4'hf
`define ISP_TICK_MID     4'h7

`endif

// >>> src/isp_pkg.sv
package isp_pkg;

   typedef enum logic [1:0] {
      ISP_FMT_8N   = 2'h0,
      ISP_FMT_7E   = 2'h1,
      ISP_FMT_7O   = 2'h2
   } isp_fmt_t;

   typedef enum logic {
      TX_IDLE = 1'b0,
      TX_SEND = 1'b1
   } isp_tx_state_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b11
   } isp_rx_state_t;

endpackage : isp_pkg

// >>> src/isp_tick_if.sv
interface isp_tick_if #(parameter int DIV_W = 14);
   logic [DIV_W-1:0] div;
   logic             tick;
   modport gen  (input div, output tick);
   modport user (output div, input tick);
endinterface : isp_tick_if

// >>> src/isp_baud_tick.sv
module isp_baud_tick #(
   parameter int DIV_W = 14
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // oversample tick
   isp_tick_if.gen   tk
);

   logic [DIV_W-1:0] cnt_q;
   logic             tick_q;

   // >= rather than == so a smaller divisor written mid-count cannot stall
   wire              wrap = cnt_q >= (tk.div - DIV_W'(1));

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= wrap ? '0 : cnt_q + DIV_W'(1);
         tick_q <= wrap;
      end
   end

   assign tk.tick = tick_q;

endmodule // isp_baud_tick

// >>> src/isp_serial_port.sv
// The register offsets and the plain strobed port were left to the implementer.
`include "isp_defines.svh"

module isp_serial_port import isp_pkg::*; #(
   parameter int unsigned CLK_HZ = `ISP_CLK_HZ,
   parameter int          DIV_W  = 14
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset,
   // register port
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // serial link
   input  wire logic       rxd,
   output logic            txd,
   input  wire logic       dsr,
   output logic            dtr
);

   localparam int unsigned DIV_300  = CLK_HZ / (`ISP_OVERSAMPLE * `ISP_BAUD_300);
   localparam int unsigned DIV_600  = CLK_HZ / (`ISP_OVERSAMPLE * `ISP_BAUD_600);
   localparam int unsigned DIV_1200 = CLK_HZ / (`ISP_OVERSAMPLE * `ISP_BAUD_1200);
   localparam int unsigned DIV_2400 = CLK_HZ / (`ISP_OVERSAMPLE * `ISP_BAUD_2400);
   localparam int unsigned DIV_4800 = CLK_HZ / (`ISP_OVERSAMPLE * `ISP_BAUD_4800);
   localparam int unsigned DIV_9600 = CLK_HZ / (`ISP_OVERSAMPLE * `ISP_BAUD_9600);

   isp_tick_if #(.DIV_W(DIV_W)) tk ();

   isp_baud_tick #(.DIV_W(DIV_W)) u_tick (
      .clk   (clk),
      .reset (reset),
      .tk    (tk.gen)
   );

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [1:0] rxd_sync_q;
   logic [1:0] dsr_sync_q;
   wire        rxd_s = rxd_sync_q[1];
   wire        dsr_s = dsr_sync_q[1];

   always_ff @(posedge clk) begin
      if (reset) begin
         rxd_sync_q <= 2'h3;
         dsr_sync_q <= 2'h0;
      end else begin
         rxd_sync_q <= {rxd_sync_q[0], rxd};
         dsr_sync_q <= {dsr_sync_q[0], dsr};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register

   logic [2:0] baud_sel_q;
   logic [1:0] fmt_q;

   wire        ctrl_wr = wr && (addr == `ISP_REG_CTRL);
   wire        stat_wr = wr && (addr == `ISP_REG_STATUS);
   wire        txd_wr  = wr && (addr == `ISP_REG_TXDATA);
   wire        rxd_rd  = rd && (addr == `ISP_REG_RXDATA);

   always_ff @(posedge clk) begin
      if (reset) begin
         baud_sel_q <= `ISP_BAUD_SEL_RST;
         fmt_q      <= `ISP_FMT_RST;
      end else if (ctrl_wr) begin
         baud_sel_q <= wdata[`ISP_CTRL_BAUD_LSB +: 3];
         fmt_q      <= wdata[`ISP_CTRL_FMT_LSB +: 2];
      end
   end

   // unused selections 6 and 7 fall back to the fastest rate
   wire [31:0] div_full = (baud_sel_q == 3'h0) ? DIV_300  :
                          (baud_sel_q == 3'h1) ? DIV_600  :
                          (baud_sel_q == 3'h2) ? DIV_1200 :
                          (baud_sel_q == 3'h3) ? DIV_2400 :
                          (baud_sel_q == 3'h4) ? DIV_4800 : DIV_9600;
   assign tk.div = div_full[DIV_W-1:0];

   // code 3 is treated as the eight bit format
   wire par_en   = (fmt_q == ISP_FMT_7E) || (fmt_q == ISP_FMT_7O);
   wire fmt_odd  = (fmt_q == ISP_FMT_7O);

   ////////////////////////////////////////////////////////////////////////////
   // transmitter

   isp_tx_state_t tx_st_q;
   logic          tx_hold_q;
   logic [7:0]    tx_hold_data_q;
   logic [7:0]    tx_byte_q;
   logic [10:0]   tx_frame_q;
   logic [3:0]    tx_bit_q;
   logic [3:0]    tx_tick_q;
   logic          txd_q;

   // only start a frame while the far end says it is ready
   wire  tx_load    = (tx_st_q == TX_IDLE) && tx_hold_q && dsr_s;
   wire  tx_bit_end = tk.tick && (tx_tick_q == `ISP_TICK_LAST);
   wire  tx_mid     = par_en ? (fmt_odd ? ~^tx_hold_data_q[6:0] : ^tx_hold_data_q[6:0])
                             : tx_hold_data_q[7];
   // stop, stop, parity or bit 7, bits 6..0, start: sent from bit 0 up
   wire [10:0] tx_frame_d = {2'b11, tx_mid, tx_hold_data_q[6:0], 1'b0};

   always_ff @(posedge clk) begin
      if (reset) begin
         tx_hold_q      <= 1'b0;
         tx_hold_data_q <= 8'h00;
      end else if (txd_wr && !tx_hold_q) begin
         tx_hold_q      <= 1'b1;
         tx_hold_data_q <= wdata;
      end else if (tx_load) begin
         tx_hold_q      <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tx_st_q    <= TX_IDLE;
         tx_byte_q  <= 8'h00;
         tx_frame_q <= 11'h7ff;
         tx_bit_q   <= 4'h0;
         tx_tick_q  <= 4'h0;
      end else begin
         case (tx_st_q)
            TX_IDLE: begin
               if (tx_load) begin
                  tx_st_q    <= TX_SEND;
                  tx_byte_q  <= tx_hold_data_q;
                  tx_frame_q <= tx_frame_d;
                  tx_bit_q   <= 4'h0;
                  tx_tick_q  <= 4'h0;
               end
            end
            TX_SEND: begin
               if (tk.tick) tx_tick_q <= tx_tick_q + 4'h1;
               if (tx_bit_end) begin
                  if (tx_bit_q == `ISP_TX_LAST_BIT) tx_st_q <= TX_IDLE;
                  else tx_bit_q <= tx_bit_q + 4'h1;
               end
            end
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) txd_q <= 1'b1;
      else txd_q <= (tx_st_q == TX_SEND) ? tx_frame_q[tx_bit_q] : 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // receiver

   isp_rx_state_t rx_st_q;
   logic [3:0]    rx_tick_q;
   logic [3:0]    rx_bit_q;
   logic [9:0]    rx_sh_q;
   logic [7:0]    rx_data_q;
   logic          rx_valid_q;
   logic          ovr_q;
   logic          ferr_q;
   logic          perr_q;
   logic          dtr_q;

   wire [9:0] rx_sh_n   = {rxd_s, rx_sh_q[9:1]};
   wire       rx_sample = (rx_st_q == RX_DATA) && tk.tick && (rx_tick_q == `ISP_TICK_LAST);
   wire       rx_done   = rx_sample && (rx_bit_q == `ISP_RX_LAST_BIT);
   wire       rx_ferr   = !(rx_sh_n[9] && rx_sh_n[8]);
   wire       rx_perr   = par_en && ((^rx_sh_n[7:0]) != fmt_odd);
   wire [7:0] rx_char   = par_en ? {1'b0, rx_sh_n[6:0]} : rx_sh_n[7:0];
   // a read in the arrival cycle frees the slot, so the new byte is kept
   wire       rx_take   = rx_done && (!rx_valid_q || rxd_rd);

   always_ff @(posedge clk) begin
      if (reset) begin
         rx_st_q   <= RX_IDLE;
         rx_tick_q <= 4'h0;
         rx_bit_q  <= 4'h0;
         rx_sh_q   <= 10'h000;
      end else begin
         case (rx_st_q)
            RX_IDLE: begin
               if (!rxd_s) begin
                  rx_st_q   <= RX_START;
                  rx_tick_q <= 4'h0;
               end
            end
            RX_START: begin
               if (tk.tick) rx_tick_q <= rx_tick_q + 4'h1;
               // mid-bit check rejects glitches shorter than half a bit
               if (tk.tick && rx_tick_q == `ISP_TICK_MID) begin
                  rx_st_q   <= rxd_s ? RX_IDLE : RX_DATA;
                  rx_tick_q <= 4'h0;
                  rx_bit_q  <= 4'h0;
               end
            end
            RX_DATA: begin
               if (tk.tick) rx_tick_q <= rx_tick_q + 4'h1;
               if (rx_sample) begin
                  rx_sh_q  <= rx_sh_n;
                  rx_bit_q <= rx_bit_q + 4'h1;
               end
               if (rx_done) rx_st_q <= RX_IDLE;
            end
            default: rx_st_q <= RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rx_data_q  <= 8'h00;
         rx_valid_q <= 1'b0;
         ovr_q      <= 1'b0;
         ferr_q     <= 1'b0;
         perr_q     <= 1'b0;
         dtr_q      <= 1'b0;
      end else begin
         if (rx_take) rx_data_q <= rx_char;
         rx_valid_q <= rx_take || (rx_valid_q && !rxd_rd);
         ovr_q  <= (rx_done && !rx_take) || (ovr_q && !(stat_wr && wdata[`ISP_ST_OVERRUN]));
         ferr_q <= (rx_done && rx_ferr) || (ferr_q && !(stat_wr && wdata[`ISP_ST_FRAME_ERR]));
         perr_q <= (rx_done && rx_perr) || (perr_q && !(stat_wr && wdata[`ISP_ST_PAR_ERR]));
         // ready to receive only while the holding slot is empty
         dtr_q  <= !rx_valid_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path

   logic [7:0] rdata_q;

   wire [7:0] status_w = {dtr_q, dsr_s, perr_q, ferr_q, ovr_q, rx_valid_q,
                          tx_st_q == TX_SEND, tx_hold_q};
   wire [7:0] rd_mux   = (addr == `ISP_REG_CTRL)   ? {3'h0, fmt_q, baud_sel_q} :
                         (addr == `ISP_REG_STATUS) ? status_w :
                         (addr == `ISP_REG_TXDATA) ? tx_hold_data_q :
                         (addr == `ISP_REG_RXDATA) ? rx_data_q : 8'h00;

   always_ff @(posedge clk) begin
      if (reset) rdata_q <= 8'h00;
      else rdata_q <= rd ? rd_mux : 8'h00;
   end

   assign rdata = rdata_q;
   assign txd   = txd_q;
   assign dtr   = dtr_q;

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_load;
      tx_st_q == TX_IDLE && tx_load;
   endsequence

   sequence s_start;
      tx_st_q == TX_SEND && tx_bit_q == 4'h0;
   endsequence

   baud_default_a: assert property (baud_sel_q == 3'h5 |-> tk.div == DIV_W'(DIV_9600))
      else $error("divisor does not match 9600 baud");
   start_bit_a: assert property (s_load |=> s_start ##1 !txd_q)
      else $error("frame did not open with a start bit");
   lsb_first_a: assert property (tx_st_q == TX_SEND && tx_bit_q == 4'h1
                                 |=> txd_q == tx_byte_q[0])
      else $error("first data bit is not the lsb");
   parity_bit_a: assert property (tx_st_q == TX_SEND && tx_bit_q == 4'h8 && par_en
         |=> txd_q == (fmt_odd ? ~^tx_byte_q[6:0] : ^tx_byte_q[6:0]))
      else $error("wrong parity bit sent");
   stop_bits_a: assert property (tx_st_q == TX_SEND && tx_bit_q >= 4'h9 |=> txd_q)
      else $error("stop bit driven low");
   frame_end_a: assert property (tx_bit_end && tx_st_q == TX_SEND
                                 && tx_bit_q == `ISP_TX_LAST_BIT |=> tx_st_q == TX_IDLE)
      else $error("frame did not end after last stop bit");
   frame_step_a: assert property (tx_bit_end && tx_st_q == TX_SEND
         && tx_bit_q != `ISP_TX_LAST_BIT
         |=> tx_st_q == TX_SEND && tx_bit_q == $past(tx_bit_q) + 4'h1)
      else $error("frame ended early or skipped a bit");
   dsr_gate_a: assert property (tx_st_q == TX_IDLE && !dsr_s |=> tx_st_q == TX_IDLE)
      else $error("transmit began without dsr");
   dtr_ready_a: assert property (rx_valid_q |=> !dtr_q)
      else $error("dtr high while receive slot full");
   rx_stop_a: assert property (rx_done && !(rxd_s && rx_sh_q[9]) |=> ferr_q)
      else $error("missing stop bit not flagged");

endmodule // isp_serial_port

// >>> tb/isp_host_model.sv
module isp_host_model (
   // clock
   input  wire logic clk,
   // serial link
   input  wire logic txd,
   output logic      rxd,
   input  wire logic dtr,
   output logic      dsr
);
   timeunit 1ns;
   timeprecision 1ps;

   // bench keeps these equal to the device setup
   int         bclk = 160;
   logic [1:0] fmt = 2'h0;
   logic       ready = 1'b1;
   logic [7:0] got;
   logic [7:0] sh;
   logic       got_par;
   logic       got_start;
   logic       got_stops;
   logic       s1;
   int         got_n = 0;
   int         low_run = 0;
   int         low_clks = 0;

   assign dsr = ready;
   initial rxd = 1'b1;

   // length of the latest low run on txd
   always @(posedge clk) begin
      if (txd === 1'b0) begin
         low_run <= low_run + 1;
      end else begin
         if (low_run != 0) begin
            low_clks <= low_run;
         end
         low_run <= 0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // mid-bit sampling, aligned to the start edge
   always begin
      @(posedge clk);
      if (txd === 1'b0) begin
         repeat (bclk / 2) @(posedge clk);
         got_start = txd;
         for (int k = 0; k < 8; k++) begin
            repeat (bclk) @(posedge clk);
            sh[k] = txd;
         end
         repeat (bclk) @(posedge clk);
         s1 = txd;
         repeat (bclk) @(posedge clk);
         got_stops = s1 & txd;
         got = (fmt == 2'h0) ? sh : {1'b0, sh[6:0]};
         got_par = (fmt == 2'h0) ? 1'b0 : sh[7];
         got_n = got_n + 1;
      end
   end

   // bad[0] flips the parity bit, bad[1] pulls the first stop bit low
   task automatic send(input logic [7:0] c, input logic [1:0] bad);
      logic [10:0] fr;
      logic        par;
      int          n;
      n = 0;
      // a polite host waits while the device is not ready
      while (dtr !== 1'b1 && n < 100000) begin
         @(posedge clk);
         n++;
      end
      par = ((fmt == 2'h2) ? ~^c[6:0] : ^c[6:0]) ^ bad[0];
      fr = (fmt == 2'h0) ? {2'b11, c, 1'b0} : {2'b11, par, c[6:0], 1'b0};
      fr[9] = ~bad[1];
      @(posedge clk);
      for (int i = 0; i < 11; i++) begin
         rxd <= fr[i];
         repeat (bclk) @(posedge clk);
      end
   endtask
endmodule // isp_host_model

// >>> tb/isp_serial_port_tb_top.sv
module isp_serial_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // small clock figure keeps frames short
   localparam int CLK_HZ = 1600000;
   logic       clk, reset, wr, rd, rxd, txd, dsr, dtr, p;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, v;
   int         failures = 0;
   int         compares = 0;
   int         n, b;
   int         bauds [8] = '{300, 600, 1200, 2400, 4800, 9600, 9600, 9600};
   logic [7:0] chars [3] = '{8'ha5, 8'h53, 8'hd3};

   isp_serial_port #(.CLK_HZ(CLK_HZ)) DUT (.clk(clk), .reset(reset), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd), .dsr(dsr),
      .dtr(dtr));
   isp_host_model host (.clk(clk), .txd(txd), .rxd(rxd), .dtr(dtr), .dsr(dsr));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         failures++;
         $display("mismatch at %0t seen %h expected %h", $time, s, e);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic set_rate(input logic [2:0] sel, input logic [1:0] f);
      wr_reg(4'h0, {3'h0, f, sel});
      host.bclk = (CLK_HZ / (16 * bauds[sel])) * 16;
      host.fmt = f;
   endtask

   task automatic wait_frame(input logic [7:0] e, input logic ep);
      int k;
      k = 0;
      while (host.got_n == n && k < 30000) begin
         @(posedge clk);
         k++;
      end
      chk(host.got_n, n + 1);
      chk(host.got_start, 1'b0);
      chk(host.got_stops, 1'b1);
      chk(host.got, e);
      chk(host.got_par, ep);
      // let the last stop bit finish before any setup change
      repeat (host.bclk) @(posedge clk);
   endtask

   task automatic end_sim();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      failures++;
      end_sim();
   end

   initial begin
      reset = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 8'h00;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rd_reg(4'h0, v);
      chk(v, 8'h05);
      rd_reg(4'h4, v);
      chk(v, 8'hc0);
      wr_reg(4'h2, 8'hff);
      rd_reg(4'h2, v);
      chk(v, 8'h00);
      rd_reg(4'h0, v);
      chk(v, 8'h05);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         wr_reg(4'h0, 8'he0 | 8'(i));
         rd_reg(4'h0, v);
         chk(v, 8'(i));
      end
      for (int i = 0; i < 3; i++) begin
         wr_reg(4'h0, 8'(i * 8 + 5));
         rd_reg(4'h0, v);
         chk(v, 8'(i * 8 + 5));
      end
      $display("field test done");
      for (int i = 0; i < 3; i++) begin
         set_rate(3'h5, 2'(i));
         n = host.got_n;
         wr_reg(4'h8, chars[i]);
         v = (i == 0) ? chars[i] : {1'b0, chars[i][6:0]};
         p = (i == 1) ? ^chars[i][6:0] : (i == 2) ? ~^chars[i][6:0] : 1'b0;
         wait_frame(v, p);
      end
      $display("format test done");
      // start bit plus low d0 make one two-bit low run
      set_rate(3'h3, 2'h0);
      b = host.bclk;
      n = host.got_n;
      wr_reg(4'h8, 8'hfe);
      wait_frame(8'hfe, 1'b0);
      chk(host.low_clks >= 2 * b - b / 16 && host.low_clks <= 2 * b, 1'b1);
      rd_reg(4'h8, v);
      chk(v, 8'hfe);
      $display("rate test done");
      set_rate(3'h5, 2'h0);
      host.ready <= 1'b0;
      repeat (4) @(posedge clk);
      n = host.got_n;
      wr_reg(4'h8, 8'h3c);
      repeat (400) @(posedge clk);
      chk(host.got_n, n);
      rd_reg(4'h4, v);
      chk(v, 8'h81);
      host.ready <= 1'b1;
      wait_frame(8'h3c, 1'b0);
      $display("handshake test done");
      for (int i = 0; i < 3; i++) begin
         set_rate(3'h5, 2'(i));
         host.send(chars[i], 2'h0);
         repeat (2) @(posedge clk);
         chk(dtr, 1'b0);
         rd_reg(4'h4, v);
         chk(v, 8'h44);
         rd_reg(4'hc, v);
         chk(v, (i == 0) ? chars[i] : {1'b0, chars[i][6:0]});
         repeat (3) @(posedge clk);
         chk(dtr, 1'b1);
      end
      set_rate(3'h5, 2'h1);
      host.send(8'h41, 2'h1);
      rd_reg(4'h4, v);
      chk(v[5], 1'b1);
      wr_reg(4'h4, 8'h20);
      rd_reg(4'hc, v);
      repeat (3) @(posedge clk);
      rd_reg(4'h4, v);
      chk(v, 8'hc0);
      // first stop bit held low must raise the framing flag
      host.send(8'h41, 2'h2);
      rd_reg(4'h4, v);
      chk(v, 8'h54);
      wr_reg(4'h4, 8'h10);
      rd_reg(4'hc, v);
      chk(v, 8'h41);
      repeat (3) @(posedge clk);
      rd_reg(4'h4, v);
      chk(v, 8'hc0);
      $display("receive test done");
      end_sim();
   end
endmodule // isp_serial_port_tb_top
